/* File: include/clkgen_cfg_pkg.sv */
// Constants, types and helper functions of the clock generator configuration slave
package clkgen_cfg_pkg;

    // Register and command indices carried by the pointer byte
    localparam logic [7:0] REG_DIVIDER = 8'h02;
    localparam logic [7:0] REG_BUS_ID = 8'h0D;
    localparam logic [7:0] CMD_COMMIT = 8'h3F;

    // Reset values, unused bits already set to one
    localparam logic [7:0] DIVIDER_RESET = 8'hC6;
    localparam logic [7:0] BUS_ID_RESET = 8'hF0;

    // Implemented bits of each register; the rest read as one
    localparam logic [7:0] DIVIDER_USED_MASK = 8'h3F;
    localparam logic [7:0] BUS_ID_USED_MASK = 8'h0F;
    localparam logic [7:0] READ_UNMAPPED = 8'hFF;

    // Field positions
    localparam int IDLE_DRIVE_BIT = 5;
    localparam int DITHER_DEPTH_BIT = 4;
    localparam int DIV_EXP_MSB = 3;
    localparam int NV_POLICY_BIT = 3;
    localparam int SLAVE_ID_MSB = 2;
    localparam int BYTE_MSB = 7;

    // Largest divide exponent
    localparam logic [3:0] DIV_EXP_MAX = 4'h8;

    // Bits per byte on the serial bus
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Upper slave address bits; value is arbitrary
    localparam logic [3:0] DEVICE_ID_DEFAULT = 4'hB;

    // Nonvolatile write time and its cycle count at the system clock
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

    // Decoded settings driven to the oscillator side
    typedef struct packed {
        logic idle_drive_low;
        logic dither_depth_2pct;
        logic [3:0] div_exp;
    } settings_s;

    // Snapshot handed to the nonvolatile store
    typedef struct packed {
        logic [7:0] divider;
        logic [7:0] bus_id;
    } nv_image_s;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_IGNORE
    } bus_state_e;

    // Clamp of the divide exponent field
    function automatic logic [3:0] clamp_exp(input logic [3:0] field);
        clamp_exp = (field > DIV_EXP_MAX) ? DIV_EXP_MAX : field;
    endfunction

    // Read value of the register chosen by the pointer
    function automatic logic [7:0] read_value(input logic [7:0] ptr, input logic [7:0] divider,
                                              input logic [7:0] bus_id);
        if (ptr == REG_DIVIDER) begin
            read_value = divider | ~DIVIDER_USED_MASK;
        end else if (ptr == REG_BUS_ID) begin
            read_value = bus_id | ~BUS_ID_USED_MASK;
        end else begin
            read_value = READ_UNMAPPED;
        end
    endfunction

endpackage

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // Next values, frozen while the clock enable is low
    always_comb begin
        nxt_meta = meta_ff;
        nxt_sync = sync_ff;
        if (ce_i) begin
            nxt_meta = async_i;
            nxt_sync = meta_ff;
        end
    end

    // Stage registers; bus lines idle high
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_ff <= reset_val_i;
            sync_ff <= reset_val_i;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;

endmodule

/* File: rtl/clock_gen_config_serial_slave.sv */
// Two-wire configuration slave with nonvolatile commit control
`timescale 1ns/1ps
module clock_gen_config_serial_slave
    import clkgen_cfg_pkg::*;
#(
    parameter int NV_WRITE_CYCLES_P = NV_WRITE_CYCLES,
    parameter logic [3:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic dither_enable_pin_i,
    input wire logic power_down_pin_n_i,
    output settings_s settings_o,
    output logic dither_active_o,
    output logic out_drive_low_o,
    output logic out_float_o,
    output logic [6:0] slave_addr_o,
    output logic nv_write_o,
    output nv_image_s nv_image_o,
    output logic nv_busy_o
);

    logic scl_s;
    logic sda_s;
    logic dither_s;
    logic pdn_n_s;
    logic scl_q_ff;
    logic sda_q_ff;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;

    bus_state_e state_ff, nxt_state;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic rw_ff, nxt_rw;
    logic first_ff, nxt_first;
    logic [7:0] ptr_ff, nxt_ptr;
    logic sda_drv_ff, nxt_sda_drv;
    logic [7:0] divider_ff, nxt_divider;
    logic [7:0] bus_id_ff, nxt_bus_id;
    logic nv_pend_ff, nxt_nv_pend;
    logic nv_busy_ff, nxt_nv_busy;
    logic [31:0] nv_cnt_ff, nxt_nv_cnt;
    logic nv_write_ff, nxt_nv_write;
    nv_image_s nv_image_ff, nxt_nv_image;
    settings_s settings_ff, nxt_settings;
    logic dither_active_ff, nxt_dither_active;
    logic drive_low_ff, nxt_drive_low;
    logic float_ff, nxt_float;

    // Bus lines and pins cross into the clock domain
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .async_i({scl_i, sda_i, dither_enable_pin_i, power_down_pin_n_i}),
        .reset_val_i(4'hF),
        .sync_o({scl_s, sda_s, dither_s, pdn_n_s})
    );

    // Bus conditions from synchronised lines; sampling at 10 ns suits both bus rates
    assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;
    assign own_addr = {DEVICE_ID, bus_id_ff[SLAVE_ID_MSB:0]};
    assign rd_byte = read_value(ptr_ff, divider_ff, bus_id_ff);

    // Serial slave, registers and store control
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_rw = rw_ff;
        nxt_first = first_ff;
        nxt_ptr = ptr_ff;
        nxt_sda_drv = sda_drv_ff;
        nxt_divider = divider_ff;
        nxt_bus_id = bus_id_ff;
        nxt_nv_pend = nv_pend_ff;
        nxt_nv_busy = nv_busy_ff;
        nxt_nv_cnt = nv_cnt_ff;
        nxt_nv_write = 1'b0;
        nxt_nv_image = nv_image_ff;
        if (stop_det) begin
            nxt_state = ST_IDLE;
            nxt_sda_drv = 1'b0;
        end else if (start_det) begin
            nxt_state = ST_ADDR;
            nxt_bit_cnt = '0;
            nxt_sda_drv = 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[BYTE_MSB-1:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
                        if (shift_ff[BYTE_MSB:1] == own_addr && !nv_busy_ff) begin
                            nxt_state = ST_ADDR_ACK;
                            nxt_sda_drv = 1'b1;
                            nxt_rw = shift_ff[0];
                        end else begin
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        nxt_bit_cnt = '0;
                        if (rw_ff) begin
                            nxt_state = ST_RD;
                            nxt_shift = rd_byte;
                            nxt_sda_drv = ~rd_byte[BYTE_MSB];
                        end else begin
                            nxt_state = ST_WR;
                            nxt_sda_drv = 1'b0;
                            nxt_first = 1'b1;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[BYTE_MSB-1:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
                        if (nv_busy_ff) begin
                            nxt_state = ST_IGNORE;
                        end else begin
                            nxt_state = ST_WR_ACK;
                            nxt_sda_drv = 1'b1;
                            if (first_ff) begin
                                nxt_first = 1'b0;
                                nxt_ptr = shift_ff;
                                if (shift_ff == CMD_COMMIT) begin
                                    nxt_nv_pend = 1'b1;
                                end
                            end else if (ptr_ff == REG_DIVIDER) begin
                                nxt_divider = shift_ff | ~DIVIDER_USED_MASK;
                                if (!bus_id_ff[NV_POLICY_BIT]) begin
                                    nxt_nv_pend = 1'b1;
                                end
                            end else if (ptr_ff == REG_BUS_ID) begin
                                nxt_bus_id = shift_ff | ~BUS_ID_USED_MASK;
                                nxt_nv_pend = 1'b1;
                            end
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        nxt_state = ST_WR;
                        nxt_sda_drv = 1'b0;
                        nxt_bit_cnt = '0;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == BYTE_BITS) begin
                            nxt_state = ST_RD_ACK;
                            nxt_sda_drv = 1'b0;
                        end else begin
                            nxt_shift = {shift_ff[BYTE_MSB-1:0], 1'b1};
                            nxt_sda_drv = ~shift_ff[BYTE_MSB-1];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise && sda_s) begin
                        nxt_state = ST_IGNORE;
                    end else if (scl_fall) begin
                        nxt_state = ST_RD;
                        nxt_bit_cnt = '0;
                        nxt_shift = rd_byte;
                        nxt_sda_drv = ~rd_byte[BYTE_MSB];
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    nxt_sda_drv = 1'b0;
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_sda_drv = 1'b0;
                end
            endcase
        end
        // Store cycle begins at STOP and blocks the bus until done
        if (nv_busy_ff) begin
            nxt_nv_cnt = nv_cnt_ff + 32'h0000_0001;
            if (nv_cnt_ff >= 32'(NV_WRITE_CYCLES_P - 1)) begin
                nxt_nv_busy = 1'b0;
            end
        end else if (stop_det && nv_pend_ff) begin
            nxt_nv_busy = 1'b1;
            nxt_nv_cnt = '0;
            nxt_nv_pend = 1'b0;
            nxt_nv_write = 1'b1;
            nxt_nv_image = '{divider: divider_ff, bus_id: bus_id_ff};
        end
    end

    // Decoded settings and output idle behaviour
    always_comb begin
        nxt_settings.idle_drive_low = divider_ff[IDLE_DRIVE_BIT];
        nxt_settings.dither_depth_2pct = divider_ff[DITHER_DEPTH_BIT];
        nxt_settings.div_exp = clamp_exp(divider_ff[DIV_EXP_MSB:0]);
        nxt_dither_active = dither_s;
        nxt_drive_low = ~pdn_n_s & divider_ff[IDLE_DRIVE_BIT];
        nxt_float = ~pdn_n_s & ~divider_ff[IDLE_DRIVE_BIT];
    end

    // State registers, frozen while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            ptr_ff <= '0;
            sda_drv_ff <= 1'b0;
            divider_ff <= DIVIDER_RESET;
            bus_id_ff <= BUS_ID_RESET;
            nv_pend_ff <= 1'b0;
            nv_busy_ff <= 1'b0;
            nv_cnt_ff <= '0;
            nv_write_ff <= 1'b0;
            nv_image_ff <= '0;
            settings_ff <= '0;
            dither_active_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            float_ff <= 1'b0;
        end else if (ce_i) begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            rw_ff <= nxt_rw;
            first_ff <= nxt_first;
            ptr_ff <= nxt_ptr;
            sda_drv_ff <= nxt_sda_drv;
            divider_ff <= nxt_divider;
            bus_id_ff <= nxt_bus_id;
            nv_pend_ff <= nxt_nv_pend;
            nv_busy_ff <= nxt_nv_busy;
            nv_cnt_ff <= nxt_nv_cnt;
            nv_write_ff <= nxt_nv_write;
            nv_image_ff <= nxt_nv_image;
            settings_ff <= nxt_settings;
            dither_active_ff <= nxt_dither_active;
            drive_low_ff <= nxt_drive_low;
            float_ff <= nxt_float;
        end
    end

    // Open-drain data line: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_drv_ff;
    assign settings_o = settings_ff;
    assign dither_active_o = dither_active_ff;
    assign out_drive_low_o = drive_low_ff;
    assign out_float_o = float_ff;
    assign slave_addr_o = own_addr;
    assign nv_write_o = nv_write_ff;
    assign nv_image_o = nv_image_ff;
    assign nv_busy_o = nv_busy_ff;

endmodule

/* File: testbench/clkgen_cfg_props.sv */
// Port assertions of the configuration slave
`timescale 1ns/1ps
module clkgen_cfg_props
    import clkgen_cfg_pkg::*;
#(
    parameter int NV_WRITE_CYCLES_P = 50,
    parameter logic [3:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic dither_enable_pin_i,
    input wire logic power_down_pin_n_i,
    input wire settings_s settings_o,
    input wire logic dither_active_o,
    input wire logic out_drive_low_o,
    input wire logic out_float_o,
    input wire logic [6:0] slave_addr_o,
    input wire logic nv_write_o,
    input wire logic nv_busy_o
);
    int busy_cnt_ff;
    int nxt_busy_cnt;
    // Length of the current busy stretch
    always_comb begin
        nxt_busy_cnt = nv_busy_o ? busy_cnt_ff + 1 : 0;
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            busy_cnt_ff <= 0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Checks
    exp_clamp_a: assert property (settings_o.div_exp <= DIV_EXP_MAX)
        else $error("Divide exponent above limit");
    pd_idle_a: assert property ((!power_down_pin_n_i) [*5] |-> (out_drive_low_o != out_float_o))
        else $error("Power-down output mode wrong");
    run_idle_a: assert property (power_down_pin_n_i [*5] |-> !(out_drive_low_o || out_float_o))
        else $error("Idle output mode outside power-down");
    dither_gate_a: assert property (($stable(dither_enable_pin_i)) [*5]
        |-> (dither_active_o == dither_enable_pin_i))
        else $error("Dither does not follow its pin");
    sda_low_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("Data line moved while clock high");
    busy_nack_a: assert property (nv_busy_o |-> !$rose(sda_oe_o))
        else $error("Acknowledge while store busy");
    store_pulse_a: assert property (nv_write_o |=> (!nv_write_o && nv_busy_o))
        else $error("Store pulse not single or not busy");
    busy_len_a: assert property ($fell(nv_busy_o) |-> (busy_cnt_ff == NV_WRITE_CYCLES_P))
        else $error("Store busy length wrong");
    dev_id_a: assert property (slave_addr_o[6:3] == DEVICE_ID)
        else $error("Upper slave address wrong");
    // Main scenarios
    cover property (nv_write_o);
    cover property ($rose(sda_oe_o));
    cover property (settings_o.div_exp == DIV_EXP_MAX);
    cover property ($fell(nv_busy_o));
endmodule
bind clock_gen_config_serial_slave clkgen_cfg_props #(
    .NV_WRITE_CYCLES_P(NV_WRITE_CYCLES_P), .DEVICE_ID(DEVICE_ID)) i_clkgen_cfg_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .dither_enable_pin_i(dither_enable_pin_i), .power_down_pin_n_i(power_down_pin_n_i),
    .settings_o(settings_o), .dither_active_o(dither_active_o),
    .out_drive_low_o(out_drive_low_o), .out_float_o(out_float_o),
    .slave_addr_o(slave_addr_o), .nv_write_o(nv_write_o), .nv_busy_o(nv_busy_o));

/* File: testbench/bus_master_model.sv */
// Behavioural two-wire bus master
`timescale 1ns/1ps
module bus_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Clock stands high and data released outside frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One bit: data set while clock low, sampled mid high; steps of 5 ns keep edges off the clock
    task automatic slot(input logic b, output logic s);
        #10 sda_o = b;
        #50 scl_o = 1'b1;
        #35 s = sda_i;
        #30 scl_o = 1'b0;
    endtask
    // Start or repeated start; an idle start first lines up between system clock edges
    task automatic start();
        if (scl_o === 1'b0) begin
            #10 sda_o = 1'b1;
            #50 scl_o = 1'b1;
        end else begin
            @(posedge clk_i);
            #2.5;
        end
        #35 sda_o = 1'b0;
        #30 scl_o = 1'b0;
    endtask
    // Stop ends the frame, bus left idle
    task automatic stop();
        #10 sda_o = 1'b0;
        #50 scl_o = 1'b1;
        #35 sda_o = 1'b1;
        #30;
    endtask
    // Byte out MSB first, ninth slot returns the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], s);
        end
        slot(1'b1, ack);
    endtask
    // Byte in, then our acknowledge or final not-acknowledge
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, d[i]);
        end
        slot(nack, s);
    endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the configuration slave
`timescale 1ns/1ps
module testbench;
    import clkgen_cfg_pkg::*;
    localparam int NV_CYC = 400;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic dith = 1'b0;
    logic power_down_pin = 1'b1;
    logic scl, m_sda, sda_o, sda_oe, nv_write, nv_busy, dact, dlow, dflt, a;
    logic [6:0] saddr;
    logic [7:0] rb;
    logic [7:0] div_m = DIVIDER_RESET;
    logic [7:0] bid_m = BUS_ID_RESET;
    logic [15:0] rnd = 16'h94B8;
    logic [15:0] img_q[$];
    settings_s set;
    nv_image_s img;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int nv_cnt = 0;
    int exp_nv = 0;
    // Open-drain data line with pull-up
    wire sda_line = m_sda & ~(sda_oe & ~sda_o);
    clock_gen_config_serial_slave #(.NV_WRITE_CYCLES_P(NV_CYC)) i_clock_gen_config_serial_slave (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .dither_enable_pin_i(dith),
        .power_down_pin_n_i(power_down_pin), .settings_o(set), .dither_active_o(dact),
        .out_drive_low_o(dlow), .out_float_o(dflt), .slave_addr_o(saddr),
        .nv_write_o(nv_write), .nv_image_o(img), .nv_busy_o(nv_busy));
    bus_master_model i_bus_master_model (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl),
        .sda_o(m_sda));
    // Clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Store monitor and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (nv_write === 1'b1) begin
            nv_cnt++;
            img_q.push_back(img);
        end
        if (cyc == 40000) begin
            error_cnt++;
            summarize();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic probe(input logic [6:0] ad, input logic e);
        i_bus_master_model.start();
        i_bus_master_model.wbyte({ad, 1'b0}, a);
        i_bus_master_model.stop();
        chk("probe ack", e, a);
    endtask
    // Let a store cycle run out before the next transfer
    task automatic settle();
        repeat (10) @(posedge clk_i);
        for (int i = 0; i < 600 && nv_busy !== 1'b0; i++) @(posedge clk_i);
    endtask
    // Write transfer, then compare with the model
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic st;
        st = (ptr != REG_DIVIDER) || !bid_m[NV_POLICY_BIT];
        i_bus_master_model.start();
        i_bus_master_model.wbyte({DEVICE_ID_DEFAULT, bid_m[2:0], 1'b0}, a);
        chk("address ack", 0, a);
        i_bus_master_model.wbyte(ptr, a);
        chk("pointer ack", 0, a);
        if (ptr != CMD_COMMIT) begin
            i_bus_master_model.wbyte(d, a);
            chk("data ack", 0, a);
        end
        i_bus_master_model.stop();
        if (ptr == REG_DIVIDER) div_m = d | ~DIVIDER_USED_MASK;
        if (ptr == REG_BUS_ID) bid_m = d | ~BUS_ID_USED_MASK;
        exp_nv += st;
        if (st) probe({DEVICE_ID_DEFAULT, bid_m[2:0]}, 1'b1);
        settle();
        chk("store count", exp_nv, nv_cnt);
        if (st) chk("store image", {div_m, bid_m}, img_q[$]);
        chk("settings", {div_m[5:4], (div_m[3:0] > 4'h8) ? 4'h8 : div_m[3:0]}, set);
        chk("slave address", {DEVICE_ID_DEFAULT, bid_m[2:0]}, saddr);
        chk("dither active", dith, dact);
        chk("idle output", {~power_down_pin & div_m[5], ~power_down_pin & ~div_m[5]}, {dlow, dflt});
    endtask
    // Pointer write, repeated start, two bytes read
    task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
        i_bus_master_model.start();
        i_bus_master_model.wbyte({DEVICE_ID_DEFAULT, bid_m[2:0], 1'b0}, a);
        i_bus_master_model.wbyte(ptr, a);
        i_bus_master_model.start();
        i_bus_master_model.wbyte({DEVICE_ID_DEFAULT, bid_m[2:0], 1'b1}, a);
        chk("read address ack", 0, a);
        i_bus_master_model.rbyte(1'b0, rb);
        chk("read byte", e, rb);
        i_bus_master_model.rbyte(1'b1, rb);
        chk("last read byte", e, rb);
        i_bus_master_model.stop();
        // A commit pointer is itself the commit command: one store at the STOP
        if (ptr == CMD_COMMIT) begin
            exp_nv += 1;
            settle();
            chk("commit store count", exp_nv, nv_cnt);
            chk("commit store image", {div_m, bid_m}, img_q[$]);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(REG_DIVIDER, div_m);
        rd(REG_BUS_ID, bid_m);
        wr(REG_DIVIDER, 8'h1F);
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            @(posedge clk_i);
            dith <= rnd[0];
            power_down_pin <= rnd[1];
            wr(REG_DIVIDER, rnd[15:8]);
            rd(REG_DIVIDER, div_m);
        end
        wr(REG_BUS_ID, 8'h0D);
        wr(REG_DIVIDER, 8'h25);
        wr(CMD_COMMIT, 8'h00);
        rd(CMD_COMMIT, READ_UNMAPPED);
        probe({DEVICE_ID_DEFAULT, ~bid_m[2:0]}, 1'b1);
        wr(REG_BUS_ID, 8'h02);
        wr(REG_DIVIDER, 8'h38);
        summarize();
    end
endmodule
